// [common/ddc_clk_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ddc_clk_if;
    import ddc_pkg::*;
    logic        diffTick;
    logic        diffLevel;
    ddc_interp_e interp;
    logic        dataClk;
    logic        dataRise;
    logic        dataFall;

    modport div  (input diffTick, diffLevel, interp,
                  output dataClk, dataRise, dataFall);
    modport user (output diffTick, diffLevel, interp,
                  input dataClk, dataRise, dataFall);
endinterface
`default_nettype wire

// [common/ddc_defines.svh]
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// --------------------------------------------------------------------
// control word layout (bits of the 8-bit word)
// --------------------------------------------------------------------
`define DDC_SLEEP_REQUEST_BIT    7
`define DDC_CONVERTER_ACTIVE_BIT 6
`define DDC_SECOND_FILTER_ON     5
`define DDC_FIRST_FILTER_ON      4
`define DDC_GAIN_TRIM_BIT3       3
`define DDC_GAIN_TRIM_BIT0       0
`define DDC_CW_PORT_MSB          9
`define DDC_CW_PORT_LSB          2
`define DDC_CW_RESET             8'h48
`define DDC_GAIN_ZERO_CODE       5'h08

// --------------------------------------------------------------------
// register map (byte addresses)
// --------------------------------------------------------------------
`define DDC_ADDR_CONFIG          12'h000
`define DDC_ADDR_STATUS          12'h004
`define DDC_ADDR_SAMPLE_A        12'h008
`define DDC_ADDR_SAMPLE_B        12'h00c
`define DDC_ADDR_BITS            12

// status word fields
`define DDC_ST_MODE_LSB          0
`define DDC_ST_SLEEP             2
`define DDC_ST_STANDBY           3
`define DDC_ST_DATACLK           4
`define DDC_ST_INTERLEAVE        5

`endif

// [common/ddc_pkg.sv]
package ddc_pkg;
    typedef enum logic [1:0] {
        DDC_INTERP_1X = 2'b00,
        DDC_INTERP_2X = 2'b01,
        DDC_INTERP_4X = 2'b10
    } ddc_interp_e;

    typedef logic [9:0] ddc_sample_t;
endpackage

// [logic/ddc_clock_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module ddc_clock_divider (
    input  wire logic clk,
    input  wire logic rst,
    ddc_clk_if.div    dv
);
    import ddc_pkg::*;

    logic cnt_q;
    logic cnt_d;
    logic clkOut_q;
    logic clkOut_d;
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;

    // ----------------------------------------------------------------
    // divide by 1, 2 or 4
    // ----------------------------------------------------------------
    always_comb begin
        cnt_d    = cnt_q;
        clkOut_d = clkOut_q;
        case (dv.interp)
            DDC_INTERP_2X: begin
                if (dv.diffTick) begin
                    clkOut_d = ~clkOut_q;
                end
            end
            DDC_INTERP_4X: begin
                if (dv.diffTick) begin
                    cnt_d = ~cnt_q;
                    if (cnt_q) begin
                        clkOut_d = ~clkOut_q;
                    end
                end
            end
            default: begin
                clkOut_d = dv.diffLevel;
                cnt_d    = 1'b0;
            end
        endcase
        rise_d = clkOut_d & ~clkOut_q;
        fall_d = ~clkOut_d & clkOut_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q    <= 1'b0;
            clkOut_q <= 1'b0;
            rise_q   <= 1'b0;
            fall_q   <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            clkOut_q <= clkOut_d;
            rise_q   <= rise_d;
            fall_q   <= fall_d;
        end
    end

    assign dv.dataClk  = clkOut_q;
    assign dv.dataRise = rise_q;
    assign dv.dataFall = fall_q;
endmodule
`default_nettype wire

// [logic/ddc_top.sv]
// Summary of operation
// - sleep bit gives power-down, inactive gives standby, filters pick 1x/2x/4x
// - four-bit channel A gain trim, 0000 +0.4 dB, 1000 0 dB, 1111 -0.35 dB
// - data clock out is input clock divided by 1, 2 or 4
// - converter outputs update once per input clock period while active, not in sleep or standby
// - non-interleaved words captured on rising edge, output next rising edge
// - interleave select high takes both channels from port A
// - interleaved: channel B on falling edge, channel A on next rise
// - interleaved: both outputs update on rise after channel A capture
// - control word on port A bits 9..2, sleep bit first, trim last
// - control word captured on falling edge of active-low strobe
// - after reset: active, 1x, 0 dB trim
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defines.svh"
module ddc_top (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          diffClockInPos,
    input  wire logic          diffClockInNeg,
    input  wire logic [9:0]    portA,
    input  wire logic [9:0]    portB,
    input  wire logic          interleaveSelect,
    input  wire logic          controlWordStrobeN,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    output logic               dataClkOut,
    output ddc_pkg::ddc_sample_t dacA,
    output ddc_pkg::ddc_sample_t dacB,
    output logic               dacUpdate,
    output logic               sleepMode,
    output logic               standbyMode,
    output ddc_pkg::ddc_interp_e interpMode,
    output logic signed [4:0]  gainStepsA
);
    import ddc_pkg::*;

    ddc_clk_if cif ();

    // ----------------------------------------------------------------
    // input clock edge and strobe edge detection
    // ----------------------------------------------------------------
    logic diffLevel;
    logic diffPrev_q;
    logic strobePrev_q;
    logic diffTick;
    logic strobeFall;

    assign diffLevel  = diffClockInPos & ~diffClockInNeg;
    assign diffTick   = diffLevel & ~diffPrev_q;
    assign strobeFall = strobePrev_q & ~controlWordStrobeN;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            diffPrev_q   <= 1'b0;
            strobePrev_q <= 1'b1;
        end else begin
            diffPrev_q   <= diffLevel;
            strobePrev_q <= controlWordStrobeN;
        end
    end

    // ----------------------------------------------------------------
    // bus slave address phase
    // ----------------------------------------------------------------
    logic                       wrPend_q;
    logic                       wrPend_d;
    logic [`DDC_ADDR_BITS-1:0]  wrAddr_q;
    logic [`DDC_ADDR_BITS-1:0]  wrAddr_d;
    logic                       busTake;
    logic                       cfgWrite;

    assign busTake  = hsel & htrans[1] & hready;
    assign cfgWrite = wrPend_q & (wrAddr_q == `DDC_ADDR_CONFIG);

    always_comb begin
        wrPend_d = busTake & hwrite;
        wrAddr_d = busTake ? haddr[`DDC_ADDR_BITS-1:0] : wrAddr_q;
    end

    // ----------------------------------------------------------------
    // control word and mode decode
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [7:0]  ctrl_d;
    logic [7:0]  newWord;
    logic        loadWord;
    ddc_interp_e interp_q;
    ddc_interp_e interp_d;

    always_comb begin
        newWord  = portA[`DDC_CW_PORT_MSB:`DDC_CW_PORT_LSB];
        loadWord = strobeFall;
        if (cfgWrite) begin
            newWord  = hwdata[7:0];
            loadWord = 1'b1;
        end
        ctrl_d   = loadWord ? newWord : ctrl_q;
        interp_d = interp_q;
        if (loadWord) begin
            case ({newWord[`DDC_SECOND_FILTER_ON],
                   newWord[`DDC_FIRST_FILTER_ON]})
                2'b00:   interp_d = DDC_INTERP_1X;
                2'b01:   interp_d = DDC_INTERP_2X;
                2'b11:   interp_d = DDC_INTERP_4X;
                default: interp_d = interp_q;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q   <= `DDC_CW_RESET;
            interp_q <= DDC_INTERP_1X;
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            interp_q <= interp_d;
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
        end
    end

    // ----------------------------------------------------------------
    // data clock divider
    // ----------------------------------------------------------------
    assign cif.diffTick  = diffTick;
    assign cif.diffLevel = diffLevel;
    assign cif.interp    = interp_q;

    ddc_clock_divider u_div (
        .clk (clk),
        .rst (rst),
        .dv  (cif.div)
    );

    // ----------------------------------------------------------------
    // sample capture pipeline
    // ----------------------------------------------------------------
    ddc_sample_t inA_q;
    ddc_sample_t inA_d;
    ddc_sample_t inB_q;
    ddc_sample_t inB_d;
    ddc_sample_t fallB_q;
    ddc_sample_t fallB_d;
    ddc_sample_t outA_q;
    ddc_sample_t outA_d;
    ddc_sample_t outB_q;
    ddc_sample_t outB_d;

    always_comb begin
        inA_d   = inA_q;
        inB_d   = inB_q;
        fallB_d = fallB_q;
        outA_d  = outA_q;
        outB_d  = outB_q;
        if (interleaveSelect && cif.dataFall) begin
            fallB_d = portA;
        end
        if (cif.dataRise) begin
            outA_d = inA_q;
            outB_d = inB_q;
            inA_d  = portA;
            if (interleaveSelect) begin
                inB_d = fallB_q;
            end else begin
                inB_d = portB;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inA_q   <= '0;
            inB_q   <= '0;
            fallB_q <= '0;
            outA_q  <= '0;
            outB_q  <= '0;
        end else begin
            inA_q   <= inA_d;
            inB_q   <= inB_d;
            fallB_q <= fallB_d;
            outA_q  <= outA_d;
            outB_q  <= outB_d;
        end
    end

    // ----------------------------------------------------------------
    // converter update and mode outputs
    // ----------------------------------------------------------------
    logic        active;
    ddc_sample_t dacA_d;
    ddc_sample_t dacB_d;
    logic        dacUpdate_d;
    logic        sleep_d;
    logic        standby_d;
    logic signed [4:0] gain_d;

    assign active = ~ctrl_q[`DDC_SLEEP_REQUEST_BIT]
                  & ctrl_q[`DDC_CONVERTER_ACTIVE_BIT];

    always_comb begin
        sleep_d     = ctrl_q[`DDC_SLEEP_REQUEST_BIT];
        standby_d   = ~ctrl_q[`DDC_SLEEP_REQUEST_BIT]
                    & ~ctrl_q[`DDC_CONVERTER_ACTIVE_BIT];
        gain_d      = $signed(`DDC_GAIN_ZERO_CODE)
                    - $signed({1'b0, ctrl_q[`DDC_GAIN_TRIM_BIT3:
                                             `DDC_GAIN_TRIM_BIT0]});
        dacUpdate_d = diffTick & active;
        dacA_d      = dacA;
        dacB_d      = dacB;
        if (diffTick && active) begin
            dacA_d = outA_q;
            dacB_d = outB_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dacA        <= '0;
            dacB        <= '0;
            dacUpdate   <= 1'b0;
            sleepMode   <= 1'b0;
            standbyMode <= 1'b0;
            interpMode  <= DDC_INTERP_1X;
            gainStepsA  <= '0;
            dataClkOut  <= 1'b0;
        end else begin
            dacA        <= dacA_d;
            dacB        <= dacB_d;
            dacUpdate   <= dacUpdate_d;
            sleepMode   <= sleep_d;
            standbyMode <= standby_d;
            interpMode  <= interp_q;
            gainStepsA  <= gain_d;
            dataClkOut  <= cif.dataClk;
        end
    end

    // ----------------------------------------------------------------
    // bus slave read data
    // ----------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [`DDC_ADDR_BITS-1:0] rdAddr;

    assign rdAddr = haddr[`DDC_ADDR_BITS-1:0];

    always_comb begin
        rdata_d = hrdata;
        if (busTake && !hwrite) begin
            if (rdAddr == `DDC_ADDR_CONFIG) begin
                rdata_d = {24'h000000, ctrl_d};
            end else if (rdAddr == `DDC_ADDR_STATUS) begin
                rdata_d = 32'h00000000;
                rdata_d[`DDC_ST_MODE_LSB +: 2] = interp_d;
                rdata_d[`DDC_ST_SLEEP]      = ctrl_d[`DDC_SLEEP_REQUEST_BIT];
                rdata_d[`DDC_ST_STANDBY]    =
                    ~ctrl_d[`DDC_SLEEP_REQUEST_BIT]
                    & ~ctrl_d[`DDC_CONVERTER_ACTIVE_BIT];
                rdata_d[`DDC_ST_DATACLK]    = cif.dataClk;
                rdata_d[`DDC_ST_INTERLEAVE] = interleaveSelect;
            end else if (rdAddr == `DDC_ADDR_SAMPLE_A) begin
                rdata_d = {22'h0, dacA};
            end else if (rdAddr == `DDC_ADDR_SAMPLE_B) begin
                rdata_d = {22'h0, dacB};
            end else begin
                rdata_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= rdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [verification/ddc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ddc_monitor
    import ddc_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [9:0]           portA,
    input wire logic                 controlWordStrobeN,
    input wire logic                 dacUpdate,
    input wire logic                 sleepMode,
    input wire logic                 standbyMode,
    input wire ddc_pkg::ddc_interp_e interpMode,
    input wire logic signed [4:0]    gainStepsA
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // control word capture
    // ----------------------------------------
    sequence s_cw;
        $fell(controlWordStrobeN);
    endsequence
    sequence s_bad;
        s_cw ##0 portA[7:6] == 2'b10;
    endsequence
    property p_sleep;
        s_cw |-> ##2 sleepMode == $past(portA[9], 2);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep wrong");
    property p_standby;
        s_cw |-> ##2 standbyMode == ($past(portA[9:8], 2) == 2'b00);
    endproperty
    a_standby: assert property (p_standby) else $error("standby wrong");
    property p_gain;
        s_cw |-> ##2 gainStepsA == 5'h08 - {1'b0, $past(portA[5:2], 2)};
    endproperty
    a_gain: assert property (p_gain) else $error("trim wrong");
    property p_interp;
        s_cw ##0 portA[7:6] != 2'b10 |-> ##2 interpMode ==
            ($past(portA[7], 2) ? DDC_INTERP_4X :
             $past(portA[6], 2) ? DDC_INTERP_2X : DDC_INTERP_1X);
    endproperty
    a_interp: assert property (p_interp) else $error("mode wrong");
    property p_keep;
        s_bad |-> ##2 $stable(interpMode);
    endproperty
    a_keep: assert property (p_keep) else $error("illegal took");
    // ----------------------------------------
    // reset state and update pulses
    // ----------------------------------------
    property p_reset;
        $past(rst) |-> interpMode == DDC_INTERP_1X && gainStepsA == 5'h00
            && !sleepMode && !standbyMode;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");
    property p_pulse;
        dacUpdate |=> !dacUpdate;
    endproperty
    a_pulse: assert property (p_pulse) else $error("update long");
    property p_quiet;
        sleepMode [*2] |-> !dacUpdate;
    endproperty
    a_quiet: assert property (p_quiet) else $error("update asleep");
endmodule
bind ddc_top ddc_monitor mon_u (
    .clk(clk), .rst(rst), .portA(portA),
    .controlWordStrobeN(controlWordStrobeN), .dacUpdate(dacUpdate),
    .sleepMode(sleepMode), .standbyMode(standbyMode),
    .interpMode(interpMode), .gainStepsA(gainStepsA)
);
`default_nettype wire

// [verification/ddc_source.sv]
`timescale 1ns/1ps
`default_nettype none
module ddc_source (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       dataClkOut,
    input  wire logic       interleave,
    input  wire logic       ctl,
    input  wire logic [7:0] ctlWord,
    output logic            diffPos,
    output logic            diffNeg,
    output logic [9:0]      portA,
    output logic [9:0]      portB,
    output logic [9:0]      pairA,
    output logic [9:0]      pairB,
    output logic            pairStb
);
    logic [2:0] cnt;
    logic [4:0] half;
    logic       dcQ;
    logic [9:0] nA;
    logic [9:0] nB;
    assign diffPos = cnt[2];
    assign diffNeg = ~cnt[2];
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 3'h0;
            half <= 5'h0;
            dcQ <= 1'b0;
            portA <= 10'h0;
            portB <= 10'h0;
            pairStb <= 1'b0;
        end else begin
            cnt <= cnt + 3'h1;
            dcQ <= dataClkOut;
            half <= (dataClkOut != dcQ) ? 5'h0 : half + 5'h1;
            pairStb <= 1'b0;
            if (interleave)
                portB <= 10'($urandom);
            if (ctl) begin
                portA <= {ctlWord, 2'b11};
            end else if (half == 5'h3 && dataClkOut) begin
                nA = 10'($urandom);
                nB = 10'($urandom);
                if (interleave)
                    portA <= nB;
            end else if (half == 5'h3) begin
                portA <= nA;
                if (!interleave)
                    portB <= nB;
                pairA <= nA;
                pairB <= nB;
                pairStb <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defines.svh"
module tb;
    import ddc_pkg::*;
    logic clk, rst = 1, il = 0, sN = 1, ctl = 0, hsel = 0, hwrite = 0;
    logic [7:0] ctlWord = 0;
    logic [1:0] htrans = 0, expI = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic hreadyout, hresp, dataClkOut, dacUpdate, sleepMode, standbyMode;
    logic diffP, diffN, pairStb, hit, dataOn = 0;
    logic [9:0] portA, portB, pairA, pairB;
    ddc_sample_t dacA, dacB;
    ddc_interp_e interpMode;
    logic signed [4:0] gainStepsA;
    logic [19:0] prevPair, pairQ[$];
    logic [7:0] w, tbl[8] = '{8'h40, 8'h5f, 8'h78, 8'h63, 8'h0a, 8'h33,
                              8'h80, 8'hc5};
    logic [7:0] modeW[3] = '{8'h48, 8'h58, 8'h78};
    int failures = 0, numChecks = 0, cyc = 0, nChg;
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    ddc_top dut_u (.clk(clk), .rst(rst), .diffClockInPos(diffP),
        .diffClockInNeg(diffN), .portA(portA), .portB(portB),
        .interleaveSelect(il), .controlWordStrobeN(sN), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .dataClkOut(dataClkOut),
        .dacA(dacA), .dacB(dacB), .dacUpdate(dacUpdate),
        .sleepMode(sleepMode), .standbyMode(standbyMode),
        .interpMode(interpMode), .gainStepsA(gainStepsA));
    ddc_source src_u (.clk(clk), .rst(rst), .dataClkOut(dataClkOut),
        .interleave(il), .ctl(ctl), .ctlWord(ctlWord), .diffPos(diffP),
        .diffNeg(diffN), .portA(portA), .portB(portB), .pairA(pairA),
        .pairB(pairB), .pairStb(pairStb));
    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic logic [1:0] expMode(logic [1:0] p, logic [7:0] v);
        if (v[5:4] == 2'b10)
            return p;
        return v[5] ? 2'h2 : {1'b0, v[4]};
    endfunction
    function automatic logic [31:0] expGain(logic [7:0] v);
        logic [4:0] g;
        g = 5'h08 - {1'b0, v[3:0]};
        return {27'h0, g};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    always @(posedge clk) begin
        if (pairStb)
            pairQ.push_back({pairA, pairB});
        if (dataOn && {dacA, dacB} !== prevPair) begin
            hit = 0;
            while (!hit && pairQ.size() > 0)
                hit = (pairQ.pop_front() === {dacA, dacB});
            nChg++;
            chk(hit, 1);
        end
        prevPair = {dacA, dacB};
    end
    // ----------------------------------------
    // bus, strobe and measurement tasks
    // ----------------------------------------
    task automatic ahb(input logic wr, input logic [31:0] a, wd);
        @(posedge clk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 32'h0);
    endtask
    task automatic cw(input logic [7:0] v);
        @(posedge clk);
        ctl <= 1;
        ctlWord <= v;
        @(posedge clk);
        sN <= 0;
        repeat (2) @(posedge clk);
        sN <= 1;
        ctl <= 0;
        #1;
        expI = expMode(expI, v);
        chk(interpMode, expI);
        chk(sleepMode, v[7]);
        chk(standbyMode, v[7:6] == 2'b00);
        chk({27'h0, gainStepsA}, expGain(v));
    endtask
    task automatic period(input int exp);
        int t0;
        @(posedge dataClkOut);
        t0 = cyc;
        @(posedge dataClkOut);
        chk(cyc - t0, exp);
    endtask
    task automatic upd(input int exp);
        int n;
        n = 0;
        repeat (80) @(posedge clk) if (dacUpdate === 1'b1) n++;
        chk(n, exp);
    endtask
    task automatic stream(input logic v);
        il <= v;
        repeat (200) @(posedge clk);
        nChg = 0;
        dataOn = 1;
        repeat (600) @(posedge clk);
        dataOn = 0;
        chk(nChg >= 30, 1);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(7));
        repeat (4) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        #1;
        chk(interpMode, 2'h0);
        chk({27'h0, gainStepsA}, 32'h0);
        ahb(0, `DDC_ADDR_CONFIG, 0);
        chk(rd, 32'h48);
        foreach (tbl[i]) cw(tbl[i]);
        repeat (12) begin
            w = 8'($urandom);
            w[4] = w[4] | w[5];
            cw(w);
        end
        foreach (modeW[k]) begin
            cw(modeW[k]);
            repeat (40) @(posedge clk);
            period(8 << k);
        end
        upd(10);
        cw(8'h80);
        upd(0);
        ahb(1, `DDC_ADDR_CONFIG, 32'h58);
        ahb(0, `DDC_ADDR_STATUS, 0);
        chk(rd & 32'h2f, 32'h01);
        ahb(0, 32'h20, 0);
        chk(rd, 32'h0);
        stream(0);
        stream(1);
        ahb(0, `DDC_ADDR_STATUS, 0);
        chk(rd & 32'h2f, 32'h21);
        tally_and_finish();
    end
endmodule
`default_nettype wire
